/* logic/rcq_pkg.sv */
// Shared constants and types of the reference qualifier and lock monitor.
// Assumes one 250 MHz clock that also serves as the 0 ppm reference.
package rcq_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NREF    = 2;   // Reference inputs
    localparam int NPLL    = 2;   // APLL and DPLL pairs
    localparam int CW      = 28;  // Window period width; the counter is one bit wider
    localparam int TW      = 16;  // Threshold and error width
    localparam int CLK_MHZ = 250; // Clock rate

    // ------------------------------------------------------------
    // Address map: group in addr[7:5], word in the low bits
    // ------------------------------------------------------------
    localparam logic [2:0] GRP_APLL = 3'h2;
    localparam logic [2:0] GRP_DPLL = 3'h3;
    localparam logic [2:0] GRP_GLOB = 3'h4;
    // Reference words, 0x00 for input 0, 0x20 for input 1
    localparam logic [2:0] RI_CTRL = 3'h0;
    localparam logic [2:0] RI_FEXP = 3'h1;
    localparam logic [2:0] RI_FTHR = 3'h2;
    localparam logic [2:0] RI_WNOM = 3'h3;
    localparam logic [2:0] RI_WTHR = 3'h4;
    localparam logic [2:0] RI_PJIT = 3'h5;
    localparam logic [2:0] RI_VTIM = 3'h6;
    localparam logic [2:0] RI_STAT = 3'h7;
    localparam int         RREGS   = 7;
    // APLL words at 0x40/0x50, DPLL words at 0x60/0x70
    localparam logic [1:0] AI_CTRL = 2'h0;
    localparam logic [1:0] AI_FEXP = 2'h1;
    localparam logic [1:0] AI_FTHR = 2'h2;
    localparam logic [1:0] DI_CTRL = 2'h0;
    localparam logic [1:0] DI_FTHR = 2'h1;
    localparam logic [1:0] DI_PTHR = 2'h2;
    localparam int         PREGS   = 3;
    // Global words at 0x80, 0x84, 0x88
    localparam logic [1:0] GI_CFG  = 2'h0;
    localparam logic [1:0] GI_LOCK = 2'h1;
    localparam logic [1:0] GI_SEL  = 2'h2;

    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int C_FREQ     = 0;  // Frequency monitor enable
    localparam int C_LATE     = 1;  // Late window enable
    localparam int C_EARLY    = 2;  // Early window enable
    localparam int C_PPS      = 3;  // Phase valid enable
    localparam int C_VTIM     = 4;  // Validation timer enable
    localparam int C_AVG_LSB  = 8;  // Averaging factor, 2 bits
    localparam int C_GATE_LSB = 12; // Gate base cycles, 20 bits
    localparam int G_RES_SEL  = 0;  // Resonator APLL lock selected
    localparam int G_RT0_LSB  = 8;  // Status pin 0 source, 4 bits
    localparam int G_RT1_LSB  = 16; // Status pin 1 source, 4 bits
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Per-input monitor flags, also the status word layout
    typedef struct packed {
        logic qual;
        logic pps;
        logic win;
        logic freq;
    } rcq_ref_flags_s;
endpackage : rcq_pkg

/* logic/rcq_win_det.sv */
// Period window detector: late (missing) and early (runt) pulses.
// Assumes a one-cycle edge pulse on the same clock.
`timescale 1ns/1ps
module rcq_win_det #(
    parameter int CW = 28
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // Edge and settings
    input  wire logic          edge_i,
    input  wire logic          late_en_i,
    input  wire logic          early_en_i,
    input  wire logic [CW-1:0] nom_i,
    input  wire logic [CW-1:0] late_i,
    input  wire logic [CW-1:0] early_i,
    // Flags
    output logic               late_o,
    output logic               early_o
);
    logic [CW:0] cnt_ff;
    logic        seen_ff;
    logic        late_ff;
    logic        early_ff;

    // Window limits from the nominal period
    wire [CW:0] late_lim  = {1'b0, nom_i} + {1'b0, late_i};
    wire [CW:0] early_lim = (nom_i > early_i) ? {1'b0, nom_i - early_i} : '0;
    wire        cnt_max   = &cnt_ff;

    // Period count, cleared by each edge
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !late_en_i) begin
            cnt_ff   <= '0;
            seen_ff  <= 1'b0;
            late_ff  <= 1'b0;
            early_ff <= 1'b0;
        end else if (edge_i) begin
            cnt_ff   <= '0;
            seen_ff  <= 1'b1;
            early_ff <= early_en_i && seen_ff && (cnt_ff < early_lim);
            if (cnt_ff <= late_lim) begin
                late_ff <= 1'b0;
            end
        end else begin
            if (!cnt_max) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
            if (cnt_ff == late_lim) begin
                late_ff <= 1'b1;
            end
        end
    end

    assign late_o  = late_ff;
    assign early_o = early_ff;
endmodule : rcq_win_det

/* logic/rcq_monitor.sv */
// Reference input qualification and PLL lock monitor.
// Assumes Avalon-MM register access, reference and APLL feedback
// pins asynchronous, DPLL error inputs on this clock.
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - PPS input uses phase valid monitor only
// - Qualify after flags clear for validation time
// - Per-input enables, thresholds, validation timer
// - Disabled monitor never flags, is ignored
// - Any flag to pins; selected flags readable
// - Frequency flag with valid/invalid hysteresis
// - Accuracy, averaging lengthen frequency measurement
// - Late window sets flag on missing pulse
// - Late and early share detector, ORed
// - Early pulse sets flag immediately
// - Early check only together with late
// - Phase valid window with jitter margin
// - Lock loss per APLL and DPLL
// - Resonator lock: paired DPLL phase only
// - DPLL frequency lock with hysteresis
// - Resonator oscillator lock against clock reference
// - DPLL phase lock with thresholds
// - Averaging lengthens lock detection delay
// - Lock flags on pins and status bits
module rcq_monitor (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    // Avalon-MM slave
    input  wire logic [7:0]                    avs_address_i,
    input  wire logic                          avs_read_i,
    input  wire logic                          avs_write_i,
    input  wire logic [31:0]                   avs_writedata_i,
    input  wire logic [3:0]                    avs_byteenable_i,
    output logic [31:0]                        avs_readdata_o,
    output logic                               avs_waitrequest_o,
    // Clock pins
    input  wire logic [rcq_pkg::NREF-1:0]      ref_clk_i,
    input  wire logic [rcq_pkg::NPLL-1:0]      pll_fb_clk_i,
    // DPLL side
    input  wire logic [rcq_pkg::NPLL-1:0]      dpll_en_i,
    input  wire logic [rcq_pkg::NPLL-1:0]      dpll_sel_ref_i,
    input  wire logic [rcq_pkg::TW-1:0]        dpll_freq_err_i [rcq_pkg::NPLL],
    input  wire logic [rcq_pkg::TW-1:0]        dpll_phase_err_i [rcq_pkg::NPLL],
    // Status
    output rcq_pkg::rcq_ref_flags_s            ref_flags_o [rcq_pkg::NREF],
    output logic [2*rcq_pkg::NPLL-1:0]         lock_loss_status_o,
    output logic [1:0]                         status_pin_o
);
    import rcq_pkg::*;

    localparam int NCH = NREF + NPLL;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    function automatic logic [31:0] abs_diff(input logic [31:0] a,
                                             input logic [31:0] b);
        return (a > b) ? a - b : b - a;
    endfunction : abs_diff

    function automatic logic [31:0] gate_len(input logic [31:0] ctrl);
        return {12'h000, ctrl[C_GATE_LSB +: 20]} << ctrl[C_AVG_LSB +: 2];
    endfunction : gate_len

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] ref_reg_ff  [NREF][RREGS];
    logic [31:0] apll_reg_ff [NPLL][PREGS];
    logic [31:0] dpll_reg_ff [NPLL][PREGS];
    logic [31:0] gcfg_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    wire [31:0]  rd_mux;

    // Address decode
    wire [2:0] grp     = avs_address_i[7:5];
    wire [2:0] ridx    = avs_address_i[4:2];
    wire       psel    = avs_address_i[4];
    wire [1:0] pidx    = avs_address_i[3:2];
    wire       req     = avs_read_i || avs_write_i;
    wire       wr_take = avs_write_i && ack_ff;
    wire       is_ref  = (grp[2:1] == 2'b00) && (ridx != RI_STAT);
    wire       p_ok    = (pidx < 2'(PREGS));
    wire       res_sel = gcfg_ff[G_RES_SEL];

    assign avs_waitrequest_o = req && !ack_ff;
    assign avs_readdata_o    = rdata_ff;

    // Handshake and read capture, answer one cycle after request
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_ff   <= 1'b0;
            rdata_ff <= RST_WORD;
        end else begin
            ack_ff <= req && !ack_ff;
            if (req && !ack_ff) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // Register writes with byte enables
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < NREF; i++) begin
                for (int j = 0; j < RREGS; j++) begin
                    ref_reg_ff[i][j] <= RST_WORD;
                end
            end
            for (int k = 0; k < NPLL; k++) begin
                for (int j = 0; j < PREGS; j++) begin
                    apll_reg_ff[k][j] <= RST_WORD;
                    dpll_reg_ff[k][j] <= RST_WORD;
                end
            end
            gcfg_ff <= RST_WORD;
        end else if (wr_take) begin
            if (is_ref) begin
                ref_reg_ff[grp[0]][ridx] <= be_merge(ref_reg_ff[grp[0]][ridx], avs_writedata_i, avs_byteenable_i);
            end
            if (grp == GRP_APLL && p_ok) begin
                apll_reg_ff[psel][pidx] <= be_merge(apll_reg_ff[psel][pidx], avs_writedata_i, avs_byteenable_i);
            end
            if (grp == GRP_DPLL && p_ok) begin
                dpll_reg_ff[psel][pidx] <= be_merge(dpll_reg_ff[psel][pidx], avs_writedata_i, avs_byteenable_i);
            end
            if (grp == GRP_GLOB && pidx == GI_CFG) begin
                gcfg_ff <= be_merge(gcfg_ff, avs_writedata_i, avs_byteenable_i);
            end
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic [NCH-1:0] pin_s1_ff;
    logic [NCH-1:0] pin_s2_ff;
    logic [NCH-1:0] pin_s3_ff;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
        end else begin
            pin_s1_ff <= {pll_fb_clk_i, ref_clk_i};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    wire [NCH-1:0] rise = pin_s2_ff & ~pin_s3_ff;

    // ------------------------------------------------------------
    // Frequency measurement: references, then APLL feedbacks
    // ------------------------------------------------------------
    logic [31:0]    fm_ctrl [NCH];
    logic [31:0]    fm_exp  [NCH];
    logic [31:0]    fm_thr  [NCH];
    logic [NCH-1:0] fm_en;
    logic [NCH-1:0] fm_flag;

    for (genvar c = 0; c < NCH; c++) begin : g_fm
        if (c < NREF) begin : g_ref
            assign fm_ctrl[c] = ref_reg_ff[c][RI_CTRL];
            assign fm_exp[c]  = ref_reg_ff[c][RI_FEXP];
            assign fm_thr[c]  = ref_reg_ff[c][RI_FTHR];
            assign fm_en[c]   = fm_ctrl[c][C_FREQ] && !fm_ctrl[c][C_PPS];
        end else begin : g_pll
            assign fm_ctrl[c] = apll_reg_ff[c-NREF][AI_CTRL];
            assign fm_exp[c]  = apll_reg_ff[c-NREF][AI_FEXP];
            assign fm_thr[c]  = apll_reg_ff[c-NREF][AI_FTHR];
            // Resonator APLL check needs its paired DPLL running
            assign fm_en[c]   = fm_ctrl[c][C_FREQ] && ((c != NREF) || (res_sel && dpll_en_i[0]));
        end

        logic [31:0] gcnt_ff;
        logic [31:0] ecnt_ff;
        logic        flag_ff;

        wire [31:0] glen   = gate_len(fm_ctrl[c]);
        wire [31:0] expc   = {8'h00, fm_exp[c][23:0]} << fm_ctrl[c][C_AVG_LSB +: 2];
        wire [31:0] ecnt_n = ecnt_ff + {31'h0, rise[c]};
        wire [31:0] err    = abs_diff(ecnt_n, expc);
        wire        done   = (gcnt_ff >= glen);

        // Count edges over the gate, compare against clock reference
        always_ff @(posedge clk_i) begin
            if (sys_rst_i || !fm_en[c]) begin
                gcnt_ff <= '0;
                ecnt_ff <= '0;
                flag_ff <= 1'b0;
            end else if (done) begin
                gcnt_ff <= '0;
                ecnt_ff <= '0;
                if (err < {16'h0, fm_thr[c][15:0]}) begin
                    flag_ff <= 1'b0;
                end else if (err > {16'h0, fm_thr[c][31:16]}) begin
                    flag_ff <= 1'b1;
                end
            end else begin
                gcnt_ff <= gcnt_ff + 32'h1;
                ecnt_ff <= ecnt_n;
            end
        end

        assign fm_flag[c] = flag_ff;
    end

    // ------------------------------------------------------------
    // Window, phase valid and validation timer per input
    // ------------------------------------------------------------
    rcq_ref_flags_s rf [NREF];

    for (genvar i = 0; i < NREF; i++) begin : g_ref
        wire [31:0] ctl     = ref_reg_ff[i][RI_CTRL];
        wire        pps_en  = ctl[C_PPS];
        wire        late_en = ctl[C_LATE] && !pps_en;
        wire        erly_en = ctl[C_EARLY] && late_en;
        wire        late_f;
        wire        early_f;
        wire        pps_f;
        wire        any_f;
        logic [31:0] vt_ff;
        logic        qual_ff;

        rcq_win_det #(.CW(CW)) u_win (
            .clk_i      (clk_i),
            .sys_rst_i  (sys_rst_i),
            .edge_i     (rise[i]),
            .late_en_i  (late_en),
            .early_en_i (erly_en),
            .nom_i      (ref_reg_ff[i][RI_WNOM][CW-1:0]),
            .late_i     ({12'h000, ref_reg_ff[i][RI_WTHR][15:0]}),
            .early_i    ({12'h000, ref_reg_ff[i][RI_WTHR][31:16]}),
            .late_o     (late_f),
            .early_o    (early_f)
        );

        rcq_win_det #(.CW(CW)) u_pps (
            .clk_i      (clk_i),
            .sys_rst_i  (sys_rst_i),
            .edge_i     (rise[i]),
            .late_en_i  (pps_en),
            .early_en_i (1'b0),
            .nom_i      (ref_reg_ff[i][RI_WNOM][CW-1:0]),
            .late_i     (ref_reg_ff[i][RI_PJIT][CW-1:0]),
            .early_i    ('0),
            .late_o     (pps_f),
            .early_o    ()
        );

        assign any_f = fm_flag[i] || late_f || early_f || pps_f;

        // Qualify once all enabled monitors stay clear long enough
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                vt_ff   <= '0;
                qual_ff <= 1'b0;
            end else if (any_f) begin
                vt_ff   <= '0;
                qual_ff <= 1'b0;
            end else if (!ctl[C_VTIM] || vt_ff >= ref_reg_ff[i][RI_VTIM]) begin
                qual_ff <= 1'b1;
            end else begin
                vt_ff <= vt_ff + 32'h1;
            end
        end

        assign rf[i].qual = qual_ff;
        assign rf[i].pps  = pps_f;
        assign rf[i].win  = late_f || early_f;
        assign rf[i].freq = fm_flag[i];
    end

    // ------------------------------------------------------------
    // DPLL frequency and phase lock detectors
    // ------------------------------------------------------------
    logic [NPLL-1:0] dfl;
    logic [NPLL-1:0] dpl;

    for (genvar d = 0; d < NPLL; d++) begin : g_dpll
        wire [31:0] dctl  = dpll_reg_ff[d][DI_CTRL];
        wire [31:0] fthr  = dpll_reg_ff[d][DI_FTHR];
        wire [31:0] pthr  = dpll_reg_ff[d][DI_PTHR];
        wire        exmpt = (d == 0) && res_sel;
        wire        fen   = dpll_en_i[d] && !exmpt;
        wire [31:0] dglen = gate_len(dctl);
        logic [47:0] acc_ff;
        wire [47:0] acc_n = acc_ff + {32'h0, dpll_freq_err_i[d]};
        logic [31:0] dg_ff;
        logic        fl_ff;
        logic        pl_ff;

        // Averaged error over the gate, lock/unlock hysteresis
        always_ff @(posedge clk_i) begin
            if (sys_rst_i || !fen) begin
                acc_ff <= '0;
                dg_ff  <= '0;
                fl_ff  <= !sys_rst_i && !dpll_en_i[d];
            end else if (dg_ff >= dglen) begin
                acc_ff <= '0;
                dg_ff  <= '0;
                if (acc_n < {32'h0, fthr[15:0]}) begin
                    fl_ff <= 1'b0;
                end else if (acc_n > {32'h0, fthr[31:16]}) begin
                    fl_ff <= 1'b1;
                end
            end else begin
                acc_ff <= acc_n;
                dg_ff  <= dg_ff + 32'h1;
            end
        end

        // Instant phase error check
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                pl_ff <= 1'b0;
            end else if (!dpll_en_i[d]) begin
                pl_ff <= 1'b1;
            end else if (dpll_phase_err_i[d] < pthr[15:0]) begin
                pl_ff <= 1'b0;
            end else if (dpll_phase_err_i[d] > pthr[31:16]) begin
                pl_ff <= 1'b1;
            end
        end

        assign dfl[d] = fl_ff;
        assign dpl[d] = pl_ff;
    end

    // ------------------------------------------------------------
    // Status collection and read mux
    // ------------------------------------------------------------
    wire [1:0]  apl     = fm_flag[NCH-1:NREF];
    wire [3:0]  loss_w  = {dfl[1] || dpl[1], dfl[0] || dpl[0], apl};
    wire [15:0] src     = {2'b00, dpl[1], dfl[1], dpl[0], dfl[0], apl, rf[1], rf[0]};
    wire [3:0]  sel0    = rf[dpll_sel_ref_i[0]];
    wire [3:0]  sel1    = rf[dpll_sel_ref_i[1]];
    wire [31:0] lock_w  = {20'h0, loss_w, 2'b00, src[13:8]};
    wire [31:0] sel_w   = {20'h0, sel1, 4'h0, sel0};
    wire [31:0] ref_w   = (ridx == RI_STAT) ? {28'h0, rf[grp[0]]} : ref_reg_ff[grp[0]][ridx];
    wire [31:0] apll_w  = p_ok ? apll_reg_ff[psel][pidx] : RST_WORD;
    wire [31:0] dpll_w  = p_ok ? dpll_reg_ff[psel][pidx] : RST_WORD;
    wire [31:0] glob_w  = (pidx == GI_CFG)  ? gcfg_ff :
                          (pidx == GI_LOCK) ? lock_w :
                          (pidx == GI_SEL)  ? sel_w : RST_WORD;
    assign rd_mux       = (grp[2:1] == 2'b00) ? ref_w :
                          (grp == GRP_APLL)   ? apll_w :
                          (grp == GRP_DPLL)   ? dpll_w :
                          (grp == GRP_GLOB)   ? glob_w : RST_WORD;

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic [1:0]     pin_ff;
    logic [3:0]     loss_ff;
    rcq_ref_flags_s out_ff [NREF];

    // Status pins pick any flag of any input
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_ff <= 2'b00;
            loss_ff <= 4'h0;
            for (int i = 0; i < NREF; i++) begin
                out_ff[i] <= '0;
            end
        end else begin
            pin_ff[0] <= src[gcfg_ff[G_RT0_LSB +: 4]];
            pin_ff[1] <= src[gcfg_ff[G_RT1_LSB +: 4]];
            loss_ff   <= loss_w;
            for (int i = 0; i < NREF; i++) begin
                out_ff[i] <= rf[i];
            end
        end
    end

    assign status_pin_o       = pin_ff;
    assign lock_loss_status_o = loss_ff;
    assign ref_flags_o        = out_ff;
endmodule : rcq_monitor

/* testbench/rcq_chk_monitor.sv */
// Checker of bus wait, qualification and lock outputs.
// Assumes it is bound to rcq_monitor.
`timescale 1ns/1ps
module rcq_chk (
    // Clock, reset, bus
    input wire logic                    clk_i,
    input wire logic                    sys_rst_i,
    input wire logic                    avs_read_i,
    input wire logic                    avs_write_i,
    input wire logic                    avs_waitrequest_o,
    // Status
    input wire logic [1:0]              dpll_en_i,
    input wire rcq_pkg::rcq_ref_flags_s ref_flags_o [2],
    input wire logic [3:0]              lock_loss_status_o,
    input wire logic [1:0]              status_pin_o
);
    import rcq_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Pending request and per-input flag summaries
    wire logic req  = avs_read_i | avs_write_i;
    wire logic bad0 = |ref_flags_o[0][2:0];
    wire logic bad1 = |ref_flags_o[1][2:0];
    a_wait_one: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait longer than one cycle");
    a_wait_idle: assert property (!req |-> !avs_waitrequest_o)
        else $error("wait without request");
    a_qual0_drop: assert property (bad0 |=> !ref_flags_o[0].qual)
        else $error("input 0 qualified while flagged");
    a_qual1_drop: assert property (bad1 |=> !ref_flags_o[1].qual)
        else $error("input 1 qualified while flagged");
    a_qual0_clean: assert property ($rose(ref_flags_o[0].qual) |-> !$past(bad0))
        else $error("input 0 qualified after a flag");
    a_dpll0_off: assert property (!dpll_en_i[0] [*3] |-> lock_loss_status_o[2])
        else $error("disabled loop 0 shown locked");
    a_dpll1_off: assert property (!dpll_en_i[1] [*3] |-> lock_loss_status_o[3])
        else $error("disabled loop 1 shown locked");
    a_rst_quiet: assert property (disable iff (1'b0) sys_rst_i |=> lock_loss_status_o == 4'h0 && status_pin_o == 2'h0)
        else $error("status not cleared by reset");
endmodule : rcq_chk
bind rcq_monitor rcq_chk chk_u (.clk_i, .sys_rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
    .dpll_en_i, .ref_flags_o, .lock_loss_status_o, .status_pin_o);

/* testbench/rcq_ref_src.sv */
// Reference pin source: one rising edge per period.
// Assumes a period of at least 4 clock cycles.
`timescale 1ns/1ps
module rcq_ref_src (
    // Clock and control
    input  wire logic       clk_i,
    input  wire logic       run_i,
    input  wire logic [7:0] period_i,
    // Pin
    output logic            ref_o
);
    logic [7:0] cnt_ff;
    // Rate kept in the window detector's range, pin low when stopped
    always_ff @(posedge clk_i) begin
        cnt_ff <= (!run_i || cnt_ff >= period_i - 8'h01) ? 8'h00 : cnt_ff + 8'h01;
        ref_o  <= run_i && cnt_ff < (period_i >> 1);
    end
endmodule : rcq_ref_src

/* testbench/rcq_tb.sv */
// Testbench of the reference qualifier and lock monitor.
// Assumes two rcq_ref_src pins and the bound checker.
`timescale 1ns/1ps
module testbench;
    import rcq_pkg::*;
    logic           clk_i = 1'b0;
    logic           sys_rst_i = 1'b1;
    logic [7:0]     avs_address_i = 8'h00;
    logic           avs_read_i = 1'b0;
    logic           avs_write_i = 1'b0;
    logic [31:0]    avs_writedata_i = 32'h0;
    logic [31:0]    avs_readdata_o;
    logic           avs_waitrequest_o;
    logic [1:0]     run = 2'h0;
    logic [7:0]     per [2] = '{8'h64, 8'h64};
    wire logic [1:0] rclk;
    logic [1:0]     dpll_en_i = 2'h0;
    logic [TW-1:0]  ferr [NPLL] = '{16'h0, 16'h0};
    logic [TW-1:0]  perr [NPLL] = '{16'h0, 16'h0};
    rcq_ref_flags_s ref_flags_o [NREF];
    logic [3:0]     lock_loss_status_o;
    logic [1:0]     status_pin_o;
    logic [31:0]    q;
    int             fail_count = 0;
    int             n_checks = 0;
    wire logic [7:0] obs = {lock_loss_status_o, ref_flags_o[1].win, ref_flags_o[1].qual,
                            ref_flags_o[0].win, ref_flags_o[0].qual};
    // Address, write data, read-back value
    logic [71:0] rows [11] = '{{8'h1c, 32'hf, 32'h8}, {8'h0c, 32'h64, 32'h64},
        {8'h10, 32'h80008, 32'h80008}, {8'h18, 32'h20, 32'h20}, {8'h2c, 32'h64, 32'h64},
        {8'h30, 32'h80008, 32'h80008}, {8'h38, 32'h20, 32'h20}, {8'hfc, 32'hffffffff, 32'h0},
        {8'h80, 32'h50100, 32'h50100}, {8'h00, 32'h16, 32'h16}, {8'h20, 32'h16, 32'h16}};
    rcq_monitor dut_u (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
        .ref_clk_i(rclk), .pll_fb_clk_i(rclk), .dpll_en_i, .dpll_sel_ref_i(2'b10),
        .dpll_freq_err_i(ferr), .dpll_phase_err_i(perr), .ref_flags_o, .lock_loss_status_o,
        .status_pin_o);
    rcq_ref_src src0_u (.clk_i, .run_i(run[0]), .period_i(per[0]), .ref_o(rclk[0]));
    rcq_ref_src src1_u (.clk_i, .run_i(run[1]), .period_i(per[1]), .ref_o(rclk[1]));
    always #2 clk_i = ~clk_i;
    // --------------------------------------------------
    // Tasks
    // --------------------------------------------------
    task results;
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // One Avalon-MM transfer, held until waitrequest is seen low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge clk_i);
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_address_i <= a;
        avs_writedata_i <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        r = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (i == 20) fail_count++;
        if (i == 20) results();
    endtask : bus
    task wait_obs(input int b, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && obs[b] !== v; i++) @(posedge clk_i);
        check({31'h0, obs[b]}, {31'h0, v});
        if (obs[b] !== v) results();
    endtask : wait_obs
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        check({24'h0, obs}, 32'h0);
        run <= 2'h3;
        foreach (rows[k]) begin
            bus(1'b1, rows[k][71:64], rows[k][63:32], q);
            bus(1'b0, rows[k][71:64], 32'h0, q);
            check(q, rows[k][31:0]);
        end
        wait_obs(0, 1'b1, 800);
        wait_obs(2, 1'b1, 800);
        run[0] <= 1'b0;
        wait_obs(1, 1'b1, 150);
        wait_obs(0, 1'b0, 3);
        @(posedge clk_i);
        check({30'h0, status_pin_o}, 32'h1);
        bus(1'b0, 8'h88, 32'h0, q);
        check(q, 32'h802);
        run[0] <= 1'b1;
        wait_obs(1, 1'b0, 400);
        repeat (28) @(posedge clk_i);
        check({31'h0, obs[0]}, 32'h0);
        wait_obs(0, 1'b1, 20);
        bus(1'b0, 8'h1c, 32'h0, q);
        check(q, 32'h8);
        per[0] <= 8'h32;
        wait_obs(1, 1'b1, 200);
        per[0] <= 8'h64;
        bus(1'b1, 8'h20, 32'h0, q);
        run[1] <= 1'b0;
        repeat (200) @(posedge clk_i);
        check({31'h0, obs[3]}, 32'h0);
        bus(1'b1, 8'h24, 32'h3, q);
        bus(1'b1, 8'h28, 32'h20002, q);
        bus(1'b1, 8'h20, 32'h100001, q);
        repeat (600) @(posedge clk_i);
        bus(1'b0, 8'h3c, 32'h0, q);
        check(q, 32'h1);
        run[1] <= 1'b1;
        repeat (600) @(posedge clk_i);
        bus(1'b0, 8'h3c, 32'h0, q);
        check(q, 32'h8);
        bus(1'b1, 8'h60, 32'h10000, q);
        bus(1'b1, 8'h64, 32'h640010, q);
        bus(1'b1, 8'h68, 32'h640010, q);
        dpll_en_i <= 2'h1;
        wait_obs(6, 1'b0, 300);
        perr[0] <= 16'h200;
        wait_obs(6, 1'b1, 300);
        perr[0] <= 16'h0;
        wait_obs(6, 1'b0, 300);
        ferr[0] <= 16'hffff;
        wait_obs(6, 1'b1, 300);
        results();
    end
endmodule : testbench
